// File: verilog/osc_select_ctl.sv
// oscillator select, gated start and slow clock calibration control
// Operation
// - slow oscillator stays on always; it times stretched modes and range one.
// - fast clock times measurements, and cycle time when neither stretched nor range one.
// - start-mode bits 19:17 of config 3: code 0 off, code 1 always on.
// - codes 2 to 5 start measuring 100, 200, 300, 400 us after power-up.
// - codes 6 and 7 are reserved; fast oscillator stays off.
// - gated modes power the oscillator for lead time plus measurement only.
// - high-quality RC select in config 13 replaces the ceramic resonator.
// - low-power RC select in config 13 clocks from that source unless high-quality RC is also selected.
// - auto-calibration bit 3 of config 2 trims slow against fast clock.
// - slow clock drives conversion counter and stretched cycle time.
// - a display driver clock is derived from the slow oscillator.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module osc_select_ctl
  import osc_pkg::*;
#(
  parameter int LEAD_STEP_CYCLES = LEAD_STEP_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // oscillator strobes, one cycle per oscillator period
  input  wire logic        slow_tick,
  input  wire logic        fast_tick,
  // converter handshake
  input  wire logic        meas_req,
  input  wire logic        meas_done,
  input  wire logic        stretched_mode,
  input  wire logic        range1_mode,
  output logic             meas_start,
  // oscillator controls
  output logic             slow_osc_en,
  output logic             res_drv_en,
  output logic             hq_rc_en,
  output logic             hq_rc_supply,
  output logic             lp_rc_en,
  output logic [7:0]       slow_trim,
  // derived clocks
  output logic             cycle_use_slow,
  output logic             conv_tick,
  output logic             lcd_clk
);
  osc_ctl_if ci ();

  // configuration
  logic        rc_supply_reg;
  logic        slow_osc_autocal_en_reg;
  logic [2:0]  start_mode_reg;
  logic        hq_rc_select_reg;
  logic        lp_rc_select_reg;
  logic        lcd_en_reg;
  // bus state
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  // control state
  meas_state_t state_reg;
  meas_state_t state_next;
  logic        fast_on_reg;
  logic        meas_start_reg;
  logic        res_reg;
  logic        hq_reg;
  logic        lp_reg;
  logic        use_slow_reg;
  logic        conv_reg;
  logic        lcd_reg;
  logic [31:0] wmask;

  wire        rsv_mode = start_mode_reg > GATE_LAST;
  wire [1:0]  src_code = hq_rc_select_reg ? 2'(SRC_HQ) :
                         lp_rc_select_reg ? 2'(SRC_LP) : 2'(SRC_RES);

  function automatic logic [31:0] reg_word(input logic [7:0] a);
    logic [31:0] w;
    w = '0;
    case (a)
      CFG0_OFS:  w[RC_SUPPLY_BIT] = rc_supply_reg;
      CFG2_OFS:  w[AUTOCAL_BIT] = slow_osc_autocal_en_reg;
      CFG3_OFS:  w[START_MSB:START_LSB] = start_mode_reg;
      CFG13_OFS: w[LCD_EN_BIT:HQ_SEL_BIT] = {lcd_en_reg, lp_rc_select_reg, hq_rc_select_reg};
      STAT_OFS:  w = {16'h0, ci.trim, 2'h0, use_slow_reg, rsv_mode,
                      (state_reg != ST_IDLE), fast_on_reg, src_code};
      default:   w = '0;
    endcase
    return w;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign wmask[8*gi +: 8] = {8{s_axi_wstrb[gi]}};
    end
  endgenerate

  // decode
  wire        wr_go    = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  wire        rd_go    = s_axi_arvalid && !rvalid_reg;
  wire        wr_hit   = s_axi_awaddr == CFG0_OFS || s_axi_awaddr == CFG2_OFS
                      || s_axi_awaddr == CFG3_OFS || s_axi_awaddr == CFG13_OFS;
  wire        rd_hit   = s_axi_araddr == CFG0_OFS || s_axi_araddr == CFG2_OFS
                      || s_axi_araddr == CFG3_OFS || s_axi_araddr == CFG13_OFS
                      || s_axi_araddr == STAT_OFS;
  wire [31:0] wr_word  = (reg_word(s_axi_awaddr) & ~wmask) | (s_axi_wdata & wmask);
  wire        gated    = start_mode_reg >= GATE_FIRST && start_mode_reg <= GATE_LAST;
  wire        lead_go  = state_reg == ST_IDLE && meas_req && gated;
  wire        fast_next = (start_mode_reg == START_ON) || (gated && state_next != ST_IDLE);
  wire [31:0] lead_prod = 32'(start_mode_reg - 3'h1) * 32'(LEAD_STEP_CYCLES);

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // bus handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= reg_word(s_axi_araddr);
        rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // configuration writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_supply_reg           <= 1'b0;
      slow_osc_autocal_en_reg <= 1'b0;
      start_mode_reg          <= START_RST;
      hq_rc_select_reg        <= 1'b0;
      lp_rc_select_reg        <= 1'b0;
      lcd_en_reg              <= 1'b0;
    end else if (wr_go) begin
      case (s_axi_awaddr)
        CFG0_OFS:  rc_supply_reg <= wr_word[RC_SUPPLY_BIT];
        CFG2_OFS:  slow_osc_autocal_en_reg <= wr_word[AUTOCAL_BIT];
        CFG3_OFS:  start_mode_reg <= wr_word[START_MSB:START_LSB];
        CFG13_OFS: begin
          hq_rc_select_reg <= wr_word[HQ_SEL_BIT];
          lp_rc_select_reg <= wr_word[LP_SEL_BIT];
          lcd_en_reg       <= wr_word[LCD_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  // measurement sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (meas_req) begin
          state_next = gated ? ST_LEAD : ST_MEAS;
        end
      end
      ST_LEAD: begin
        if (ci.lead_done) begin
          state_next = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (meas_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  assign ci.lead_start  = lead_go;
  assign ci.lead_cycles = lead_prod[LEAD_W-1:0];
  assign ci.cal_run     = slow_osc_autocal_en_reg && fast_on_reg;
  assign ci.fast_tick   = fast_tick;
  assign ci.slow_tick   = slow_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= ST_IDLE;
      meas_start_reg <= 1'b0;
      fast_on_reg    <= 1'b0;
      res_reg        <= 1'b0;
      hq_reg         <= 1'b0;
      lp_reg         <= 1'b0;
    end else begin
      state_reg      <= state_next;
      meas_start_reg <= state_reg != ST_MEAS && state_next == ST_MEAS;
      fast_on_reg    <= fast_next;
      res_reg        <= fast_next && src_code == 2'(SRC_RES);
      hq_reg         <= fast_next && src_code == 2'(SRC_HQ);
      lp_reg         <= fast_next && src_code == 2'(SRC_LP);
    end
  end

  // slow clock derived outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      use_slow_reg <= 1'b0;
      conv_reg     <= 1'b0;
      lcd_reg      <= 1'b0;
    end else begin
      use_slow_reg <= stretched_mode || range1_mode;
      conv_reg     <= slow_tick;
      if (!lcd_en_reg) begin
        lcd_reg <= 1'b0;
      end else if (slow_tick) begin
        lcd_reg <= !lcd_reg;
      end
    end
  end

  lead_timer u_lead (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tl      (ci.tmr)
  );

  slow_cal u_cal (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cl      (ci.cal)
  );

  // the slow oscillator is never gated
  assign slow_osc_en    = 1'b1;
  assign meas_start     = meas_start_reg;
  assign res_drv_en     = res_reg;
  assign hq_rc_en       = hq_reg;
  assign lp_rc_en       = lp_reg;
  assign hq_rc_supply   = rc_supply_reg;
  assign slow_trim      = ci.trim;
  assign cycle_use_slow = use_slow_reg;
  assign conv_tick      = conv_reg;
  assign lcd_clk        = lcd_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_lead_end;
    state_reg == ST_LEAD && ci.lead_done;
  endsequence
  sequence s_start_now;
    meas_start && fast_on_reg;
  endsequence

  property p_slow_on;
    slow_osc_en && (conv_tick == $past(slow_tick));
  endproperty
  a_slow_on: assert property (p_slow_on) else $error("slow clock path broken");
  property p_cycle_sel;
    (stretched_mode || range1_mode) ##1 1 |-> cycle_use_slow;
  endproperty
  a_cycle_sel: assert property (p_cycle_sel) else $error("cycle clock not slow");
  property p_mode_off;
    start_mode_reg == START_OFF |=> !fast_on_reg && !res_drv_en;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("fast osc on in mode 0");
  property p_mode_on;
    start_mode_reg == START_ON |=> fast_on_reg;
  endproperty
  a_mode_on: assert property (p_mode_on) else $error("fast osc off in mode 1");
  property p_lead_start;
    s_lead_end |=> s_start_now;
  endproperty
  a_lead_start: assert property (p_lead_start) else $error("start not after lead");
  property p_reserved;
    rsv_mode |=> !fast_on_reg;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode powered osc");
  property p_gate_off;
    gated && state_reg == ST_MEAS && meas_done ##1 gated |-> !fast_on_reg;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gated osc left on");
  property p_gate_idle;
    gated && state_reg == ST_IDLE && !meas_req |=> !fast_on_reg;
  endproperty
  a_gate_idle: assert property (p_gate_idle) else $error("gated osc on while idle");
  property p_hq_pick;
    hq_rc_select_reg && fast_next |=> hq_rc_en && !lp_rc_en && !res_drv_en;
  endproperty
  a_hq_pick: assert property (p_hq_pick) else $error("hq rc not chosen");
  property p_lp_pick;
    lp_rc_select_reg && !hq_rc_select_reg && fast_next |=> lp_rc_en && !res_drv_en;
  endproperty
  a_lp_pick: assert property (p_lp_pick) else $error("lp rc not chosen");
  property p_cal_run;
    !slow_osc_autocal_en_reg |=> $stable(slow_trim);
  endproperty
  a_cal_run: assert property (p_cal_run) else $error("trim moved with autocal off");
  property p_lcd;
    lcd_en_reg && slow_tick |=> lcd_clk != $past(lcd_clk);
  endproperty
  a_lcd: assert property (p_lcd) else $error("lcd clock missed toggle");
endmodule
`default_nettype wire

// File: verilog/osc_pkg.sv
// constants for the oscillator select and calibration block
package osc_pkg;
  // clock and timing
  localparam int CLK_MHZ         = 200;
  localparam int LEAD_STEP_US    = 100;
  localparam int LEAD_STEP_CYC   = LEAD_STEP_US * CLK_MHZ;
  localparam int LEAD_W          = 17;
  // nominal fast ticks per slow period
  localparam int FAST_KHZ        = 4000;
  localparam int SLOW_KHZ        = 10;
  localparam int FAST_PER_SLOW   = FAST_KHZ / SLOW_KHZ;
  localparam int CAL_TOL         = 2;
  localparam int CAL_CNT_W       = 12;
  // register byte offsets
  localparam logic [7:0] CFG0_OFS  = 8'h00;
  localparam logic [7:0] CFG2_OFS  = 8'h08;
  localparam logic [7:0] CFG3_OFS  = 8'h0c;
  localparam logic [7:0] CFG13_OFS = 8'h34;
  localparam logic [7:0] STAT_OFS  = 8'h40;
  // field positions
  localparam int RC_SUPPLY_BIT = 0;
  localparam int AUTOCAL_BIT   = 3;
  localparam int START_LSB     = 17;
  localparam int START_MSB     = 19;
  localparam int HQ_SEL_BIT    = 0;
  localparam int LP_SEL_BIT    = 1;
  localparam int LCD_EN_BIT    = 2;
  // start-mode codes
  localparam logic [2:0] START_OFF  = 3'h0;
  localparam logic [2:0] START_ON   = 3'h1;
  localparam logic [2:0] GATE_FIRST = 3'h2;
  localparam logic [2:0] GATE_LAST  = 3'h5;
  // reset values
  localparam logic [2:0] START_RST = 3'h0;
  localparam logic [7:0] TRIM_RST  = 8'h80;
  // responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // fast clock sources
  typedef enum logic [1:0] {SRC_RES, SRC_HQ, SRC_LP} fast_src_t;
  typedef enum {ST_IDLE, ST_LEAD, ST_MEAS} meas_state_t;
endpackage

// File: verilog/osc_ctl_if.sv
// links between the oscillator control and its timer and calibrator
`timescale 1ns/100ps
`default_nettype none
interface osc_ctl_if;
  import osc_pkg::*;
  logic              lead_start;
  logic [LEAD_W-1:0] lead_cycles;
  logic              lead_done;
  logic              cal_run;
  logic              fast_tick;
  logic              slow_tick;
  logic [7:0]        trim;
  modport ctl (output lead_start, lead_cycles, cal_run, fast_tick, slow_tick,
               input lead_done, trim);
  modport tmr (input lead_start, lead_cycles, output lead_done);
  modport cal (input cal_run, fast_tick, slow_tick, output trim);
endinterface
`default_nettype wire

// File: verilog/lead_timer.sv
// lead delay counter between oscillator power-up and measurement start
`timescale 1ns/100ps
`default_nettype none
module lead_timer
  import osc_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control link
  osc_ctl_if.tmr    tl
);
  logic [LEAD_W-1:0] cnt_reg;
  logic              run_reg;
  logic [LEAD_W-1:0] elapsed_reg;
  logic [LEAD_W-1:0] load_reg;

  assign tl.lead_done = run_reg && (cnt_reg == LEAD_W'(1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (tl.lead_start) begin
      cnt_reg <= tl.lead_cycles;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - LEAD_W'(1);
      run_reg <= (cnt_reg != LEAD_W'(1));
    end
  end

  // helper for checking the delay length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elapsed_reg <= '0;
      load_reg    <= '0;
    end else if (tl.lead_start) begin
      elapsed_reg <= LEAD_W'(1);
      load_reg    <= tl.lead_cycles;
    end else if (run_reg) begin
      elapsed_reg <= elapsed_reg + LEAD_W'(1);
    end
  end

  property p_lead_len;
    @(posedge aclk) disable iff (!aresetn) tl.lead_done |-> elapsed_reg == load_reg;
  endproperty
  a_lead_len: assert property (p_lead_len) else $error("lead delay length wrong");
endmodule
`default_nettype wire

// File: verilog/slow_cal.sv
// trims the slow oscillator by counting fast ticks per slow period
`timescale 1ns/100ps
`default_nettype none
module slow_cal
  import osc_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control link
  osc_ctl_if.cal    cl
);
  logic [CAL_CNT_W-1:0] cnt_reg;
  logic                 armed_reg;
  logic [7:0]           trim_reg;
  wire                  too_slow = cnt_reg > CAL_CNT_W'(FAST_PER_SLOW + CAL_TOL);
  wire                  too_fast = cnt_reg < CAL_CNT_W'(FAST_PER_SLOW - CAL_TOL);
  wire                  judge    = cl.cal_run && cl.slow_tick && armed_reg;

  assign cl.trim = trim_reg;

  // first slow period after enabling is partial, so it only arms
  always_ff @(posedge aclk) begin
    if (!aresetn || !cl.cal_run) begin
      cnt_reg   <= '0;
      armed_reg <= 1'b0;
    end else if (cl.slow_tick) begin
      cnt_reg   <= '0;
      armed_reg <= 1'b1;
    end else if (cl.fast_tick && !(&cnt_reg)) begin
      cnt_reg <= cnt_reg + CAL_CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_reg <= TRIM_RST;
    end else if (judge && too_slow && trim_reg != 8'hff) begin
      trim_reg <= trim_reg + 8'h01;
    end else if (judge && too_fast && trim_reg != 8'h00) begin
      trim_reg <= trim_reg - 8'h01;
    end
  end

  property p_trim_only_cal;
    @(posedge aclk) disable iff (!aresetn) !cl.cal_run |=> $stable(trim_reg);
  endproperty
  a_trim_only_cal: assert property (p_trim_only_cal) else $error("trim moved without cal");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the oscillator select control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import osc_pkg::*;
  // short lead step keeps the gated-mode runs brief
  localparam int STEP = 20;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        slow_tick, fast_tick, meas_req, meas_done, stretched_mode, range1_mode;
  logic        meas_start, slow_osc_en, res_drv_en, hq_rc_en, hq_rc_supply, lp_rc_en;
  logic [7:0]  slow_trim;
  logic        cycle_use_slow, conv_tick, lcd_clk;
  logic        fast_on;
  int          fails;
  int          checks;
  int          lat;

  assign fast_on = res_drv_en | hq_rc_en | lp_rc_en;

  osc_select_ctl #(.LEAD_STEP_CYCLES(STEP)) u_osc_select_ctl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .slow_tick(slow_tick), .fast_tick(fast_tick), .meas_req(meas_req),
    .meas_done(meas_done), .stretched_mode(stretched_mode), .range1_mode(range1_mode),
    .meas_start(meas_start), .slow_osc_en(slow_osc_en), .res_drv_en(res_drv_en),
    .hq_rc_en(hq_rc_en), .hq_rc_supply(hq_rc_supply), .lp_rc_en(lp_rc_en),
    .slow_trim(slow_trim), .cycle_use_slow(cycle_use_slow), .conv_tick(conv_tick),
    .lcd_clk(lcd_clk)
  );

  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // address and data are offered together; each is dropped once its own ready is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!aw_done || !w_done) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready  <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd   = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // one measurement: request, wait for start, then finish it
  task automatic meas(input int exp_lat, input logic exp_en, input logic exp_after);
    @(posedge aclk);
    meas_req <= 1'b1;
    @(posedge aclk);
    meas_req <= 1'b0;
    lat = 1;
    #1;
    chk("fast_on_after_req", fast_on, exp_en);
    while (meas_start !== 1'b1 && lat < 200) begin
      @(posedge aclk);
      #1;
      lat++;
    end
    chk("start_latency", lat, exp_lat);
    chk("fast_on_at_start", fast_on, exp_en);
    @(posedge aclk);
    #1;
    chk("start_pulse_end", meas_start, 1'b0);
    @(posedge aclk);
    meas_done <= 1'b1;
    @(posedge aclk);
    meas_done <= 1'b0;
    #1;
    chk("fast_on_after_done", fast_on, exp_after);
  endtask

  task automatic slow_period(input int n);
    repeat (n) @(posedge aclk);
    slow_tick <= 1'b1;
    @(posedge aclk);
    slow_tick <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    checks = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {slow_tick, fast_tick, meas_req, meas_done, stretched_mode, range1_mode} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("slow_osc_en", slow_osc_en, 1'b1);
    chk("slow_trim_rst", slow_trim, TRIM_RST);
    chk("fast_on_rst", fast_on, 1'b0);
    chk("lcd_clk_rst", lcd_clk, 1'b0);
    axi_wr(CFG0_OFS, 32'h1, 4'hf);
    chk("cfg0_resp", resp, RESP_OKAY);
    axi_rd(CFG0_OFS);
    chk("cfg0_read", rd[0], 1'b1);
    chk("hq_rc_supply", hq_rc_supply, 1'b1);
    axi_wr(8'h20, 32'hffffffff, 4'hf);
    chk("unmapped_wr", resp, RESP_SLVERR);
    axi_rd(8'h20);
    chk("unmapped_rd", resp, RESP_SLVERR);
    axi_wr(STAT_OFS, 32'h0, 4'hf);
    chk("stat_wr", resp, RESP_SLVERR);
    axi_rd(STAT_OFS);
    chk("stat_trim", rd[15:8], TRIM_RST);
    // every start-mode code, gated ones included
    for (int c = 0; c < 8; c++) begin
      axi_wr(CFG3_OFS, 32'(c) << START_LSB, 4'hf);
      axi_rd(STAT_OFS);
      chk("reserved_flag", rd[4], c >= 6);
      meas((c >= 2 && c <= 5) ? (c - 1) * STEP + 1 : 1, c >= 1 && c <= 5, c == 1);
    end
    // a write without lane 2 must leave the start field alone
    axi_wr(CFG3_OFS, 32'(START_ON) << START_LSB, 4'hf);
    axi_wr(CFG3_OFS, 32'h0, 4'b1011);
    repeat (2) @(posedge aclk);
    #1;
    chk("start_kept", res_drv_en, 1'b1);
    for (int s = 0; s < 4; s++) begin
      axi_wr(CFG13_OFS, 32'(s), 4'h1);
      repeat (2) @(posedge aclk);
      #1;
      chk("res_drv_en", res_drv_en, s == 0);
      chk("hq_rc_en", hq_rc_en, s[0]);
      chk("lp_rc_en", lp_rc_en, s == 2);
      axi_rd(STAT_OFS);
      chk("src_field", rd[1:0], (s == 2) ? 2'h2 : 2'(s != 0));
      chk("stat_fast_on", rd[2], 1'b1);
    end
    for (int m = 1; m < 5; m++) begin
      @(posedge aclk);
      stretched_mode <= m[0];
      range1_mode    <= m[1];
      repeat (2) @(posedge aclk);
      #1;
      chk("cycle_use_slow", cycle_use_slow, m != 4);
      axi_rd(STAT_OFS);
      chk("stat_use_slow", rd[5], m != 4);
    end
    axi_wr(CFG13_OFS, 32'h4, 4'h1);
    for (int k = 1; k < 4; k++) begin
      @(posedge aclk);
      slow_tick <= 1'b1;
      @(posedge aclk);
      slow_tick <= 1'b0;
      #1;
      chk("conv_tick", conv_tick, 1'b1);
      chk("lcd_clk", lcd_clk, k[0]);
      @(posedge aclk);
      #1;
      chk("conv_tick_end", conv_tick, 1'b0);
    end
    // fast strobe every cycle: 500-cycle periods run long, 300 run short
    axi_wr(CFG13_OFS, 32'h0, 4'h1);
    // autocal is only switched on here, with stretched_mode low
    axi_wr(CFG2_OFS, 32'h8, 4'hf);
    @(posedge aclk);
    fast_tick <= 1'b1;
    slow_period(10);
    slow_period(500);
    chk("trim_up", slow_trim, 8'h81);
    slow_period(500);
    chk("trim_up2", slow_trim, 8'h82);
    slow_period(300);
    chk("trim_down", slow_trim, 8'h81);
    axi_wr(CFG2_OFS, 32'h0, 4'hf);
    slow_period(500);
    slow_period(500);
    chk("trim_held", slow_trim, 8'h81);
    axi_rd(STAT_OFS);
    chk("stat_trim_now", rd[15:8], 8'h81);
    chk("slow_osc_en_end", slow_osc_en, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
